// File: pmb_ctrl.sv
// Power-mode controller with boot vector choice, APB register slave.
// Assumes wake and reset sources are asynchronous levels; flash read port runs on mclk.
//
// The address map and the APB slave port were chosen for this implementation.
`include "pmb_defines.svh"
module pmb_ctrl import pmb_pkg::*; #(
   parameter int NPERIPH = 8,
   parameter logic [15:0] BOOT_VEC = 16'hfc00,
   parameter logic [15:0] SIG_ADDR = 16'h3ffe
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake and reset sources
   input wire logic irq_any,
   input wire logic [5:0] wake_src,
   input wire logic [2:0] rst_src,
   // Flash signature read
   output logic flash_rd_req,
   output logic [15:0] flash_addr,
   input wire logic flash_rd_ack,
   input wire logic [7:0] flash_rd_data,
   // Core control
   output logic core_hold,
   output logic [15:0] boot_vector,
   output logic core_clk_en,
   output logic [NPERIPH-1:0] periph_clk_en,
   // Oscillators and regulators
   output logic fast_osc_a_en,
   output logic fast_osc_b_en,
   output logic slow_osc_en,
   output logic timer34_slow_clk_en,
   output logic reg_low_bias,
   output logic ldo18_en,
   output logic power_nets_on,
   output logic pin_hold,
   output logic vreg5_en
);

   // Read mux and gate register serve at most eight peripheral clocks
   if (NPERIPH < 1 || NPERIPH > 8) begin
      $error("NPERIPH must be 1 to 8");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [8:0] sync1_ff;
   logic [8:0] sync2_ff;
   logic [8:0] sync3_ff;
   logic [8:0] src_ff;
   logic cmp_fall;
   logic wake_any;
   logic rst_any;
   logic rst_hard;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync1_ff <= 9'h000;
         sync2_ff <= 9'h000;
         sync3_ff <= 9'h000;
         src_ff <= 9'h000;
      end else begin
         sync1_ff <= {rst_src, wake_src};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         // Level moves only once two late stages agree, filtering one-stage glitches
         src_ff <= (sync2_ff & sync3_ff) | (src_ff & (sync2_ff ^ sync3_ff));
      end
   end

   // R10 comparator falling edge
   assign cmp_fall = src_ff[`PMB_WK_CMP] & ~sync2_ff[`PMB_WK_CMP] & ~sync3_ff[`PMB_WK_CMP];
   // R10 any wake source
   assign wake_any = (|src_ff[4:0]) | cmp_fall;
   assign rst_any = |src_ff[8:6];
   assign rst_hard = src_ff[`PMB_RS_PIN] | src_ff[`PMB_RS_POR];

   ////////////////////////////////////////////////////////////////////////////////
   // APB access decode

   pmb_state_t state_ff;
   pmb_state_t nxt_state;
   logic setup;
   logic wr;
   logic hit;
   logic deep_exit;
   logic [1:0] rc_ff;
   logic [1:0] ck_ff;
   logic [NPERIPH-1:0] gate_ff;
   logic [NPERIPH-1:0] nxt_gate;
   logic [5:0] wake_cause_ff;
   logic boot_present_ff;
   logic [2:0] mode_code;
   logic [31:0] rd_mux;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite & hit;
   assign deep_exit = (state_ff == PMB_STOP || state_ff == PMB_SHUTDOWN) && nxt_state == PMB_BOOT_REQ;

   always_comb begin
      case (state_ff)
         PMB_NORMAL: mode_code = `PMB_MD_NORMAL;
         PMB_IDLE: mode_code = `PMB_MD_IDLE;
         PMB_SUSPEND: mode_code = `PMB_MD_SUSPEND;
         PMB_SNOOZE: mode_code = `PMB_MD_SNOOZE;
         PMB_STOP: mode_code = `PMB_MD_STOP;
         PMB_SHUTDOWN: mode_code = `PMB_MD_SHUTDOWN;
         default: mode_code = `PMB_MD_BOOT;
      endcase
   end

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `PMB_OFS_PCF: begin
            rd_mux[`PMB_PCF_IDLE] = (state_ff == PMB_IDLE);
            rd_mux[`PMB_PCF_STOP] = (state_ff == PMB_STOP || state_ff == PMB_SHUTDOWN);
         end
         `PMB_OFS_PCS: begin
            rd_mux[`PMB_PCS_SUSPEND] = (state_ff == PMB_SUSPEND);
            rd_mux[`PMB_PCS_SNOOZE] = (state_ff == PMB_SNOOZE);
         end
         `PMB_OFS_RC: rd_mux[1:0] = rc_ff;
         `PMB_OFS_CK: rd_mux[1:0] = ck_ff;
         `PMB_OFS_GATE: rd_mux[NPERIPH-1:0] = gate_ff;
         `PMB_OFS_STAT: rd_mux[13:0] = {wake_cause_ff, 3'h0, boot_present_ff, ~core_hold, mode_code};
         `PMB_OFS_BVEC: rd_mux[15:0] = boot_vector;
         default: hit = 1'b0;
      endcase
   end

   // Zero wait states: pready rises in the first access cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         if (setup) begin
            prdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers, set back to their reset values after a stop or shutdown exit

   always_ff @(posedge mclk) begin
      if (!reset_n || deep_exit) begin
         rc_ff <= `PMB_RST_RC;
         ck_ff <= `PMB_RST_CK;
         gate_ff <= NPERIPH'(`PMB_RST_GATE);
      end else if (wr) begin
         case (paddr)
            `PMB_OFS_RC: rc_ff <= pwdata[1:0];
            `PMB_OFS_CK: ck_ff <= pwdata[1:0];
            `PMB_OFS_GATE: gate_ff <= pwdata[NPERIPH-1:0];
            default: ;
         endcase
      end
   end

   // Gate value seen by the clock enables at the same edge as the write, with no lag
   assign nxt_gate = (wr && paddr == `PMB_OFS_GATE) ? pwdata[NPERIPH-1:0] : gate_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   logic go_stop;
   logic go_idle;
   logic go_susp;
   logic go_snz;

   assign go_stop = wr && paddr == `PMB_OFS_PCF && pwdata[`PMB_PCF_STOP];
   assign go_idle = wr && paddr == `PMB_OFS_PCF && pwdata[`PMB_PCF_IDLE];
   // R4 suspend refused unless running on fast oscillator a
   assign go_susp = wr && paddr == `PMB_OFS_PCS && pwdata[`PMB_PCS_SUSPEND] && !ck_ff[`PMB_CK_SRC];
   // R6 snooze refused unless running on fast oscillator a
   assign go_snz = wr && paddr == `PMB_OFS_PCS && pwdata[`PMB_PCS_SNOOZE] && !ck_ff[`PMB_CK_SRC];

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         PMB_BOOT_REQ: nxt_state = PMB_BOOT_WAIT;
         PMB_BOOT_WAIT: begin
            if (flash_rd_ack) begin
               nxt_state = PMB_NORMAL;
            end
         end
         PMB_NORMAL: begin
            // R12 stop with regulator select clear, R14 shutdown with it set
            if (go_stop) begin
               nxt_state = rc_ff[`PMB_RC_DEEPSEL] ? PMB_SHUTDOWN : PMB_STOP;
            // R3 idle entry
            end else if (go_idle) begin
               nxt_state = PMB_IDLE;
            end else if (go_susp) begin
               nxt_state = PMB_SUSPEND;
            end else if (go_snz) begin
               nxt_state = PMB_SNOOZE;
            end
         end
         // R11 idle resumes on any interrupt
         PMB_IDLE: begin
            if (irq_any) begin
               nxt_state = PMB_NORMAL;
            end
         end
         // R11 resume on wake, no reset
         PMB_SUSPEND, PMB_SNOOZE: begin
            if (wake_any) begin
               nxt_state = PMB_NORMAL;
            end
         end
         // R13 any reset source ends stop
         PMB_STOP: begin
            if (rst_any) begin
               nxt_state = PMB_BOOT_REQ;
            end
         end
         // R15 only pin or power-on reset ends shutdown
         PMB_SHUTDOWN: begin
            if (rst_hard) begin
               nxt_state = PMB_BOOT_REQ;
            end
         end
         default: nxt_state = PMB_BOOT_REQ;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_ff <= PMB_BOOT_REQ;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wake_cause_ff <= 6'h00;
      end else if ((state_ff == PMB_SUSPEND || state_ff == PMB_SNOOZE) && wake_any) begin
         wake_cause_ff <= {cmp_fall, src_ff[4:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Boot vector selection

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         flash_rd_req <= 1'b0;
         flash_addr <= 16'h0000;
         core_hold <= 1'b1;
         boot_vector <= `PMB_RESET_VEC;
         boot_present_ff <= 1'b0;
      end else begin
         // R19 signature fetched while core is held
         flash_rd_req <= (nxt_state == PMB_BOOT_WAIT);
         flash_addr <= SIG_ADDR;
         core_hold <= (nxt_state == PMB_BOOT_REQ || nxt_state == PMB_BOOT_WAIT);
         if (state_ff == PMB_BOOT_WAIT && flash_rd_ack) begin
            // R17 signature compare
            boot_present_ff <= (flash_rd_data == `PMB_SIG_PRESENT);
            // R18 vector choice
            boot_vector <= (flash_rd_data == `PMB_SIG_PRESENT) ? BOOT_VEC : `PMB_RESET_VEC;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, oscillator and regulator controls other than vreg5_en follow the next mode

   logic nx_active;
   logic nx_sleep;
   logic nx_deep;

   assign nx_active = nxt_state inside {PMB_BOOT_REQ, PMB_BOOT_WAIT, PMB_NORMAL, PMB_IDLE};
   assign nx_sleep = (nxt_state == PMB_SUSPEND || nxt_state == PMB_SNOOZE);
   assign nx_deep = (nxt_state == PMB_STOP || nxt_state == PMB_SHUTDOWN);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         core_clk_en <= 1'b0;
         periph_clk_en <= '0;
         fast_osc_a_en <= 1'b1;
         fast_osc_b_en <= 1'b0;
         slow_osc_en <= 1'b1;
         timer34_slow_clk_en <= 1'b0;
         reg_low_bias <= 1'b0;
         ldo18_en <= 1'b1;
         power_nets_on <= 1'b1;
         pin_hold <= 1'b0;
         vreg5_en <= 1'b1;
      end else begin
         // R2 core runs only in normal mode
         core_clk_en <= (nxt_state == PMB_NORMAL);
         // R1 unused peripherals gated, R3 kept in idle
         periph_clk_en <= (nxt_state == PMB_NORMAL || nxt_state == PMB_IDLE) ? nxt_gate : '0;
         // R8 fast oscillators stop in suspend and snooze
         fast_osc_a_en <= nx_active & ~ck_ff[`PMB_CK_SRC];
         fast_osc_b_en <= nx_active & ck_ff[`PMB_CK_SRC];
         slow_osc_en <= ~nx_deep;
         // R9 timers 3 and 4 on the slow oscillator
         timer34_slow_clk_en <= nx_sleep & ck_ff[`PMB_CK_T34LF];
         // R5 normal bias in suspend, R7 low bias in snooze
         reg_low_bias <= (nxt_state == PMB_SNOOZE);
         // R13 1.8 V stays on in stop, R15 off in shutdown
         ldo18_en <= (nxt_state != PMB_SHUTDOWN);
         power_nets_on <= ~nx_deep;
         pin_hold <= nx_deep;
         // R16 5 V regulator follows its enable
         vreg5_en <= rc_ff[`PMB_RC_V5EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   property p_gate;
      (state_ff == PMB_NORMAL || state_ff == PMB_IDLE) |-> (periph_clk_en == gate_ff);
   endproperty
   a_gate: assert property (p_gate) else $error("peripheral clocks differ from gate register"); // R1

   property p_normal;
      state_ff == PMB_NORMAL |-> core_clk_en && (fast_osc_a_en || fast_osc_b_en);
   endproperty
   a_normal: assert property (p_normal) else $error("core or oscillator off in normal mode"); // R2

   property p_idle;
      ((state_ff == PMB_NORMAL && go_idle && !go_stop) |=> (state_ff == PMB_IDLE && !core_clk_en))
         and ((state_ff == PMB_IDLE && !irq_any) |=> state_ff == PMB_IDLE);
   endproperty
   a_idle: assert property (p_idle) else $error("idle entry or hold wrong"); // R3

   property p_susp_refused;
      (state_ff == PMB_NORMAL && wr && paddr == `PMB_OFS_PCS && ck_ff[`PMB_CK_SRC]) |=> state_ff == PMB_NORMAL;
   endproperty
   a_susp_refused: assert property (p_susp_refused) else $error("sleep entered on wrong clock"); // R4

   property p_bias;
      (state_ff == PMB_SUSPEND |-> !reg_low_bias) and (state_ff == PMB_SNOOZE |-> reg_low_bias);
   endproperty
   a_bias: assert property (p_bias) else $error("regulator bias wrong in sleep"); // R7

   property p_sleep_clk;
      (state_ff == PMB_SUSPEND || state_ff == PMB_SNOOZE) |->
         !core_clk_en && periph_clk_en == '0 && !fast_osc_a_en && !fast_osc_b_en;
   endproperty
   a_sleep_clk: assert property (p_sleep_clk) else $error("clock running in sleep"); // R8

   property p_wake;
      ((state_ff == PMB_SUSPEND || state_ff == PMB_SNOOZE) && cmp_fall) |=> state_ff == PMB_NORMAL && !core_hold;
   endproperty
   a_wake: assert property (p_wake) else $error("comparator fall did not resume"); // R10

   property p_stop;
      state_ff == PMB_STOP |-> ldo18_en && pin_hold && !power_nets_on && vreg5_en == rc_ff[`PMB_RC_V5EN];
   endproperty
   a_stop: assert property (p_stop) else $error("stop mode outputs wrong"); // R13

   property p_shutdown_hold;
      (state_ff == PMB_SHUTDOWN && !rst_hard) |=> state_ff == PMB_SHUTDOWN && !ldo18_en;
   endproperty
   a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left without hard reset"); // R15

   property p_vector;
      (state_ff == PMB_BOOT_WAIT && flash_rd_ack) |=>
         boot_vector == ((($past(flash_rd_data) == `PMB_SIG_PRESENT)) ? BOOT_VEC : `PMB_RESET_VEC) && !core_hold;
   endproperty
   a_vector: assert property (p_vector) else $error("boot vector wrong"); // R18

   property p_hold;
      !core_hold |-> state_ff != PMB_BOOT_REQ && state_ff != PMB_BOOT_WAIT;
   endproperty
   a_hold: assert property (p_hold) else $error("core released before signature read"); // R19

endmodule

// File: pmb_defines.svh
// Offsets, field positions, reset values and fixed codes of the power-mode controller.
// Assumes an 8-bit APB byte address and 32-bit data, one aligned word per register.
// Operation
// R1: Clocks of digital peripherals that software marks unused are gated off.
// R2: Normal mode clocks the core and all enabled peripherals.
// R3: Idle bit halts the core, keeps peripherals clocked, any interrupt ends it.
// R4: Suspend needs system clock on fast oscillator a, then the suspend bit.
// R5: Suspend keeps the regulators in normal bias for fast wake.
// R6: Snooze needs system clock on fast oscillator a, then the snooze bit.
// R7: Snooze puts the regulators into low bias current.
// R8: Suspend and snooze stop core, peripheral clocks and both fast oscillators.
// R9: Timers 3 and 4 may count from the slow oscillator in suspend or snooze.
// R10: USB, timer 4, SPI, I2C slave, port match or comparator 0 fall wake.
// R11: Waking from idle, suspend or snooze resumes execution without reset.
// R12: Stop entry: clear regulator select bit, then set the stop bit.
// R13: Stop cuts power nets, keeps 1.8 V on, holds pins, exits on any reset.
// R14: Shutdown entry: set regulator select bit, then set the stop bit.
// R15: Shutdown turns 1.8 V off, holds pins, exits on pin or power-on reset.
// R16: Stop and shutdown keep the 5 V regulator running when enabled.
// R17: Signature byte 0xA5 before the lock byte means a bootloader is present.
// R18: After reset fetch the bootloader vector if present, else 0x0000.
// R19: The signature is read during reset sequencing before the first fetch.
`ifndef PMB_DEFINES_SVH
`define PMB_DEFINES_SVH
`define PMB_OFS_PCF 8'h00
`define PMB_OFS_PCS 8'h04
`define PMB_OFS_RC 8'h08
`define PMB_OFS_CK 8'h0c
`define PMB_OFS_GATE 8'h10
`define PMB_OFS_STAT 8'h14
`define PMB_OFS_BVEC 8'h18
`define PMB_PCF_IDLE 0
`define PMB_PCF_STOP 1
`define PMB_PCS_SUSPEND 0
`define PMB_PCS_SNOOZE 1
`define PMB_RC_DEEPSEL 0
`define PMB_RC_V5EN 1
`define PMB_CK_SRC 0
`define PMB_CK_T34LF 1
`define PMB_RST_RC 2'h2
`define PMB_RST_CK 2'h0
`define PMB_RST_GATE 8'hff
`define PMB_WK_CMP 5
`define PMB_RS_PIN 6
`define PMB_RS_POR 7
`define PMB_SIG_PRESENT 8'ha5
`define PMB_RESET_VEC 16'h0000
`define PMB_MD_NORMAL 3'h0
`define PMB_MD_IDLE 3'h1
`define PMB_MD_SUSPEND 3'h2
`define PMB_MD_STOP 3'h3
`define PMB_MD_SNOOZE 3'h4
`define PMB_MD_SHUTDOWN 3'h5
`define PMB_MD_BOOT 3'h7
`endif

// File: pmb_pkg.sv
// Types of the power-mode controller.
// Assumes nothing of its surroundings.
package pmb_pkg;
   typedef enum logic [2:0] {
      PMB_BOOT_REQ,
      PMB_BOOT_WAIT,
      PMB_NORMAL,
      PMB_IDLE,
      PMB_SUSPEND,
      PMB_SNOOZE,
      PMB_STOP,
      PMB_SHUTDOWN
   } pmb_state_t;
endpackage

// File: testbench.sv
// Self-checking bench for the power-mode controller: APB register access, boot vector choice,
// sleep and deep modes. Assumes pmb_ctrl with default parameters and a 10 MHz mclk.
`include "pmb_defines.svh"
module testbench import pmb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic irq_any = 1'b0;
   logic [5:0] wake_src = 6'h00;
   logic [2:0] rst_src = 3'h0;
   logic flash_rd_req, flash_rd_ack = 1'b0;
   logic [15:0] flash_addr, boot_vector;
   logic [7:0] flash_rd_data = 8'h00;
   logic core_hold, core_clk_en, fast_osc_a_en, fast_osc_b_en, slow_osc_en, timer34_slow_clk_en;
   logic reg_low_bias, ldo18_en, power_nets_on, pin_hold, vreg5_en;
   logic [7:0] periph_clk_en;
   int err_total = 0;
   int cmp_count = 0;
   logic [31:0] q;
   logic e;
   int i;
   always #50 mclk = ~mclk;
   pmb_ctrl pmb_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_any(irq_any),
      .wake_src(wake_src), .rst_src(rst_src), .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
      .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data), .core_hold(core_hold),
      .boot_vector(boot_vector), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
      .fast_osc_a_en(fast_osc_a_en), .fast_osc_b_en(fast_osc_b_en), .slow_osc_en(slow_osc_en),
      .timer34_slow_clk_en(timer34_slow_clk_en), .reg_low_bias(reg_low_bias), .ldo18_en(ldo18_en),
      .power_nets_on(power_nets_on), .pin_hold(pin_hold), .vreg5_en(vreg5_en));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim();
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task timed_out();
      err_total++;
      end_sim();
   endtask
   // Request held from setup until pready is sampled high
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rq, output logic er);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) timed_out();
      rq = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, q, e);
   endtask
   task rd(input logic [7:0] a);
      apb(a, 1'b0, 32'h0, q, e);
   endtask
   // Answers the signature read; the vector must settle before the core runs
   task boot(input logic [7:0] sig, input logic [15:0] vec);
      int n;
      for (n = 0; n < 32; n++) begin
         @(negedge mclk);
         if (flash_rd_req === 1'b1) break;
      end
      if (n == 32) timed_out();
      chk(core_hold, 1'b1);
      chk(core_clk_en, 1'b0);
      chk(flash_addr, 16'h3ffe);
      @(posedge mclk);
      flash_rd_ack <= 1'b1;
      flash_rd_data <= sig;
      @(posedge mclk);
      flash_rd_ack <= 1'b0;
      flash_rd_data <= ~sig;
      @(negedge mclk);
      chk(core_hold, 1'b0);
      chk(boot_vector, vec);
      chk(core_clk_en, 1'b1);
   endtask
   // Wake passes a synchroniser, so the delay is bounded, not fixed
   task wait_core();
      int n;
      for (n = 0; n < 32; n++) begin
         @(negedge mclk);
         if (core_clk_en === 1'b1) break;
      end
      if (n == 32) timed_out();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({pready, core_hold, ldo18_en, power_nets_on}, 4'h7);
      @(posedge mclk);
      reset_n <= 1'b1;
      boot(8'ha5, 16'hfc00);
      chk(periph_clk_en, 8'hff);
      rd(`PMB_OFS_RC);
      chk(q[1:0], 2'h2);
      rd(`PMB_OFS_CK);
      chk(q[1:0], 2'h0);
      rd(`PMB_OFS_BVEC);
      chk(q[15:0], 16'hfc00);
      rd(8'h1c);
      chk({e, q}, {1'b1, 32'h0});
      wr(`PMB_OFS_GATE, 32'h0000000f);
      @(negedge mclk);
      chk(periph_clk_en, 8'h0f);
      wr(`PMB_OFS_GATE, 32'h000000ff);
      wr(`PMB_OFS_PCF, 32'h1);
      @(negedge mclk);
      chk({core_clk_en, periph_clk_en}, 9'h0ff);
      rd(`PMB_OFS_STAT);
      chk(q[2:0], 3'h1);
      @(posedge mclk);
      irq_any <= 1'b1;
      wait_core();
      chk(core_hold, 1'b0);
      @(posedge mclk);
      irq_any <= 1'b0;
      // sleep refused while running from the second oscillator
      wr(`PMB_OFS_CK, 32'h1);
      wr(`PMB_OFS_PCS, 32'h1);
      @(negedge mclk);
      chk(core_clk_en, 1'b1);
      chk({fast_osc_a_en, fast_osc_b_en}, 2'h1);
      wr(`PMB_OFS_CK, 32'h2);
      // every wake source, suspend and snooze alternating
      for (i = 0; i < 6; i++) begin
         if (i == 5) begin
            @(posedge mclk);
            wake_src <= 6'h20;
            repeat (6) @(posedge mclk);
         end
         wr(`PMB_OFS_PCS, (i % 2 == 1) ? 32'h2 : 32'h1);
         @(negedge mclk);
         chk({core_clk_en, fast_osc_a_en, fast_osc_b_en, periph_clk_en}, 11'h000);
         chk(reg_low_bias, i % 2);
         chk(timer34_slow_clk_en, 1'b1);
         chk(slow_osc_en, 1'b1);
         rd(`PMB_OFS_STAT);
         chk(q[2:0], (i % 2 == 1) ? 3'h4 : 3'h2);
         @(posedge mclk);
         wake_src <= (i == 5) ? 6'h00 : (6'h01 << i);
         wait_core();
         chk(core_hold, 1'b0);
         rd(`PMB_OFS_STAT);
         chk(q[13:8], 6'h01 << i);
         @(posedge mclk);
         wake_src <= 6'h00;
         repeat (8) @(posedge mclk);
      end
      // stop entry and exit on a reset other than pin or power-on
      wr(`PMB_OFS_RC, 32'h2);
      wr(`PMB_OFS_PCF, 32'h2);
      @(negedge mclk);
      chk({power_nets_on, ldo18_en, pin_hold, core_clk_en}, 4'h6);
      chk(vreg5_en, 1'b1);
      chk(slow_osc_en, 1'b0);
      @(posedge mclk);
      rst_src <= 3'h4;
      boot(8'h00, 16'h0000);
      @(posedge mclk);
      rst_src <= 3'h0;
      rd(`PMB_OFS_CK);
      chk(q[1:0], 2'h0);
      // shutdown ignores other resets, leaves on pin then power-on
      for (i = 0; i < 2; i++) begin
         repeat (8) @(posedge mclk);
         wr(`PMB_OFS_RC, 32'h3);
         wr(`PMB_OFS_PCF, 32'h2);
         @(negedge mclk);
         chk({power_nets_on, ldo18_en, pin_hold, vreg5_en}, 4'h3);
         @(posedge mclk);
         rst_src <= 3'h4;
         repeat (10) @(posedge mclk);
         @(negedge mclk);
         chk({flash_rd_req, ldo18_en, core_clk_en}, 3'h0);
         @(posedge mclk);
         rst_src <= 3'h0;
         repeat (6) @(posedge mclk);
         rst_src <= (i == 0) ? 3'h1 : 3'h2;
         boot(8'ha5, 16'hfc00);
         @(posedge mclk);
         rst_src <= 3'h0;
      end
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      timed_out();
   end
endmodule
